/* File: common/spsi_pkg.sv */
// Constants, types and register map of the safe position signal interface
package spsi_pkg;
  // Clock and time base
  localparam int CLK_KHZ = 50000;
  localparam int SKEW_MS = 750;
  localparam int LAG_MS = 650;
  localparam int SLS_SKEW_MS = 1000;
  localparam int RAMP_MS = 500;
  localparam int SKEW_CYC = SKEW_MS * CLK_KHZ;
  localparam int LAG_CYC = LAG_MS * CLK_KHZ;
  localparam int SLS_SKEW_CYC = SLS_SKEW_MS * CLK_KHZ;
  localparam int RAMP_CYC = RAMP_MS * CLK_KHZ;
  localparam int TMR_W = 32;
  // Serial position link
  localparam int POS_BITS_SHORT = 24;
  localparam int POS_BITS_LONG = 31;
  localparam int ERR_BITS = 1;
  localparam int FRAME_W = POS_BITS_LONG + ERR_BITS;
  localparam int LINK_MIN_KBAUD = 100;
  localparam int LINK_MAX_KBAUD = 400;
  localparam int SEC_LINK_KBAUD = 167;
  localparam int OWN_LINK_KBAUD = 250;
  localparam logic [15:0] HALF_DIV_RST = 16'(CLK_KHZ / (2 * OWN_LINK_KBAUD));
  localparam logic [15:0] SEC_HALF_DIV = 16'(CLK_KHZ / (2 * SEC_LINK_KBAUD));
  localparam int MONO_US = 20;
  localparam int MONO_CYC = MONO_US * CLK_KHZ / 1000;
  localparam int FRAME_INT_US = 1000;
  localparam int FRAME_INT_MAX_US = 8000;
  localparam int FRAME_CYC = FRAME_INT_US * CLK_KHZ / 1000;
  // Register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] DIV_OFS = 8'h04;
  localparam logic [7:0] STAT_OFS = 8'h08;
  localparam logic [7:0] POS_OFS = 8'h0c;
  // Control register layout, bit 4 down to bit 0
  typedef struct packed {
    logic brake_used;
    logic sls_enable;
    logic ramp_used;
    logic long_frame;
    logic link_master;
  } spsi_cfg_t;
  localparam logic [4:0] CFG_RST = 5'h1c;
  // Test signal pair codes {signal 1, signal 2}
  localparam logic [1:0] MOT_STILL = 2'h3;
  localparam logic [1:0] MOT_FWD = 2'h2;
  localparam logic [1:0] MOT_BACK = 2'h1;
  localparam logic [1:0] MOT_SAFE = 2'h0;
  // Supervisor states
  typedef enum logic [3:0] {
    ST_STOPPED = 4'h1,
    ST_READY = 4'h2,
    ST_RUN = 4'h4,
    ST_RAMP = 4'h8
  } spsi_state_t;
  // Status register layout, bit 11 down to bit 0
  typedef struct packed {
    logic [3:0] state;
    logic sls_active;
    logic [1:0] motion;
    logic f_sls;
    logic f_skew;
    logic f_safe_req;
    logic f_estop;
    logic latched;
  } spsi_status_t;
endpackage

/* File: logic/spsi_link.sv */
// Serial position port: clock master or listener, 24+1 or 31+1 bit frames
`timescale 1ns/1ps
`default_nettype none
module spsi_link import spsi_pkg::*; #(
  parameter int FRAME_GAP = FRAME_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic master,
  input wire logic long_frame,
  input wire logic [15:0] half_div,
  input wire logic [30:0] pos,
  input wire logic err,
  input wire logic link_clk,
  output logic clk_out,
  output logic clk_oe,
  output logic data_out
);
  generate
    if (FRAME_GAP < 1 || FRAME_GAP >= 2 ** 24) begin : g_bad
      $error("FRAME_GAP out of range");
    end
  endgenerate

  logic gen_clk, gen_run, sel_q, busy;
  logic [15:0] div;
  logic [23:0] gap;
  logic [15:0] mono;
  logic [5:0] cnt;
  logic [FRAME_W-1:0] shreg;
  logic sel, fall_ev, rise_ev;
  logic [5:0] nbits;

  // One edge detector serves both roles
  assign sel = master ? gen_clk : link_clk; // RL4
  assign fall_ev = sel_q & ~sel;
  assign rise_ev = ~sel_q & sel;
  assign nbits = long_frame ? 6'(POS_BITS_LONG + ERR_BITS) : 6'(POS_BITS_SHORT + ERR_BITS); // RL5 RL6
  assign clk_out = gen_clk;
  assign clk_oe = master; // RL4

  always_ff @(posedge clk or posedge rst) begin
    if (rst) sel_q <= 1'b1;
    else sel_q <= sel;
  end

  // Master clock generator; idles high, one frame per gap interval
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gen_clk <= 1'b1;
      gen_run <= 1'b0;
      div <= 16'h0000;
      gap <= 24'h000000;
    end else if (!master) begin
      gen_clk <= 1'b1;
      gen_run <= 1'b0;
      gap <= 24'h000000;
    end else if (!gen_run) begin
      gen_clk <= 1'b1;
      div <= 16'h0000;
      if (busy) gap <= 24'h000000;
      else if (gap == 24'(FRAME_GAP - 1)) begin
        gap <= 24'h000000;
        gen_run <= 1'b1;
        gen_clk <= 1'b0;
      end else gap <= gap + 24'h000001;
    end else if (div >= half_div - 16'h0001) begin
      div <= 16'h0000;
      // Stop high after the last bit so the monoflop can end the frame
      if (gen_clk && cnt == nbits) gen_run <= 1'b0;
      else gen_clk <= ~gen_clk;
    end else div <= div + 16'h0001;
  end

  // Shifter: latch on first falling edge, present MSB first on rises
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy <= 1'b0;
      cnt <= 6'h00;
      shreg <= '0;
      data_out <= 1'b1;
      mono <= 16'h0000;
    end else if (!busy) begin
      mono <= 16'h0000;
      data_out <= 1'b1;
      if (fall_ev) begin
        busy <= 1'b1;
        cnt <= 6'h00;
        data_out <= 1'b0;
        shreg <= long_frame ? {pos, err} : {pos[POS_BITS_SHORT-1:0], err, 7'h00}; // RL5 RL6
      end
    end else begin
      if (fall_ev || rise_ev) mono <= 16'h0000;
      else mono <= mono + 16'h0001;
      if (rise_ev && cnt < nbits) begin
        data_out <= shreg[FRAME_W-1];
        shreg <= {shreg[FRAME_W-2:0], 1'b0};
        cnt <= cnt + 6'h01;
      end
      // A stalled clock ends the frame, complete or not
      if (mono == 16'(MONO_CYC - 1)) begin
        busy <= 1'b0;
        data_out <= 1'b1;
      end
    end
  end

  chk_listener_no_drive: assert property (@(posedge clk) disable iff (rst)
    !master |-> !clk_oe && clk_out) else $error("listener drives link clock"); // RL4
  chk_frame_bit_count: assert property (@(posedge clk) disable iff (rst)
    cnt <= nbits) else $error("frame longer than configured"); // RL5 RL6
endmodule // spsi_link
`default_nettype wire

/* File: logic/spsi_top.sv */
// Safe position signal interface: plausibility, stop latching, serial port
//
// Our own choices: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// Operation
// [RL1] Controller requests safe state by dropping both test signals.
// [RL2] Test signals must match sensed motion within 0.75 s.
// [RL3] Test signals may lag up to 650 ms; tolerated without fault.
// [RL4] Serial port acts as listener or clock master, software selected.
// [RL5] Short variant frame: 24 binary position bits then one error bit.
// [RL6] Long variant frame: 31 binary position bits then one error bit.
// [RL7] A master controller clocks frames at 100 to 400 kBaud.
// [RL8] A master controller starts frames every 0 to 8 ms.
// [RL9] Our link rate differs from the 167 kBaud secondary link.
// [RL10] Stop ramp request output is low while a stop is requested.
// [RL11] Unused ramp output means torque is cut at once, no ramp.
// [RL12] Torque cutoff outputs are high in run, low to remove torque.
// [RL13] Both channels of dual outputs switch together at equal levels.
// [RL14] Brake outputs high release the brake, low engage it.
// [RL15] Speed limit source holds both channels high, both low requests.
// [RL16] Speed limit channels change together within 1 s.
// [RL17] Without a speed limit source the function is disabled.
// [RL18] A commanded stop stays latched until a manual reset.
// [RL19] Reset is recognised on the reset input's falling edge.
// [RL20] Reset is accepted only while no protective fault is present.
// [RL21] Reset causes no motion; start accepted only after a reset.
// [RL22] Dual-channel emergency stop input causes a latched stop.
// [RL23] Pair codes: both still, 1 forward, 2 backward, none safe.
// [RL24] Both test signals inactive forces the safe state.
// [RL25] Direction versus sensed motion disagreeing past skew forces stop.
// [RL26] Speed limit channels disagreeing past skew flags fault and stops.
module spsi_top import spsi_pkg::*; #(
  parameter int SKEW_LIMIT = SKEW_CYC,
  parameter int SLS_LIMIT = SLS_SKEW_CYC,
  parameter int RAMP_LIMIT = RAMP_CYC,
  parameter int FRAME_GAP = FRAME_CYC
) (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic TEST_SIG1,
  input wire logic TEST_SIG2,
  input wire logic [1:0] LIMITED_SPEED_REQUEST_N,
  input wire logic [1:0] EMERGENCY_STOP_BUTTON,
  input wire logic RESET_BUTTON,
  input wire logic START_BUTTON,
  input wire logic [30:0] PRIMARY_POSITION,
  input wire logic PRIMARY_POSITION_ERR,
  input wire logic PRIMARY_POSITION_VALID,
  input wire logic LINK_CLK_IN,
  output logic LINK_CLK_OUT,
  output logic LINK_CLK_OE,
  output logic LINK_DATA_OUT,
  output logic STOP_RAMP_REQUEST_OUT,
  output logic [1:0] TORQUE_CUTOFF_OUT,
  output logic [1:0] BRAKE_HOLD_OUT,
  output logic LIMITED_SPEED_ACTIVE
);
  localparam int NPIN = 9;

  generate
    if (SKEW_LIMIT < 1 || SLS_LIMIT < 1 || RAMP_LIMIT < 1) begin : g_bad_time
      $error("time limits must be at least one cycle");
    end
    if (LAG_MS > SKEW_MS) begin : g_bad_lag
      $error("tolerated lag exceeds plausibility skew");
    end
    if (HALF_DIV_RST == SEC_HALF_DIV) begin : g_bad_rate
      $error("link rate must differ from the secondary link");
    end
  endgenerate

  // Pin synchronisers, two flops per pin
  logic [NPIN-1:0] pin_raw, pin_s1, pin_s2;
  assign pin_raw = {LINK_CLK_IN, START_BUTTON, RESET_BUTTON, EMERGENCY_STOP_BUTTON,
                    LIMITED_SPEED_REQUEST_N, TEST_SIG2, TEST_SIG1};
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_sync
      always_ff @(posedge CLK or posedge SYS_RST) begin
        // The link clock pin resets to its idle high level so no false frame follows reset
        if (SYS_RST) begin
          pin_s1[gi] <= 1'(gi == NPIN - 1);
          pin_s2[gi] <= 1'(gi == NPIN - 1);
        end else begin
          pin_s1[gi] <= pin_raw[gi];
          pin_s2[gi] <= pin_s1[gi];
        end
      end
    end
  endgenerate

  logic [1:0] test_pair, sls_n, estop;
  logic rst_btn, start_btn, link_clk;
  assign test_pair = {pin_s2[0], pin_s2[1]};
  assign sls_n = pin_s2[3:2];
  assign estop = pin_s2[5:4];
  assign rst_btn = pin_s2[6];
  assign start_btn = pin_s2[7];
  assign link_clk = pin_s2[8];

  // Register file
  spsi_cfg_t cfg;
  logic [15:0] half_div;
  logic [30:0] last_pos;
  spsi_status_t status;
  logic ph_valid, ph_write;
  logic [7:0] ph_addr;

  // AHB-Lite slave: zero wait states, always OKAY
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;

  // Address phase capture
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ph_valid <= 1'b0;
      ph_write <= 1'b0;
      ph_addr <= 8'h00;
    end else if (HREADY) begin
      ph_valid <= HSEL && HTRANS[1];
      ph_write <= HWRITE;
      ph_addr <= HADDR[7:0];
    end
  end

  // Writes land in the data phase
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      cfg <= spsi_cfg_t'(CFG_RST);
      half_div <= HALF_DIV_RST;
    end else if (ph_valid && ph_write) begin
      if (ph_addr == CTRL_OFS) cfg <= spsi_cfg_t'(HWDATA[4:0]); // RL4 RL11 RL17
      // A zero divider would stall the master clock; keep the old one
      if (ph_addr == DIV_OFS && HWDATA[15:0] != 16'h0000) half_div <= HWDATA[15:0]; // RL9
    end
  end

  // Read data registered from the address phase; unmapped reads zero
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) HRDATA <= 32'h00000000;
    else if (HREADY && HSEL && HTRANS[1] && !HWRITE) begin
      case (HADDR[7:0])
        CTRL_OFS: HRDATA <= {27'h0000000, cfg};
        DIV_OFS: HRDATA <= {16'h0000, half_div};
        STAT_OFS: HRDATA <= {20'h00000, status};
        POS_OFS: HRDATA <= {1'b0, last_pos};
        default: HRDATA <= 32'h00000000;
      endcase
    end
  end

  // Motion seen by the sensor, updated on each position sample
  logic [1:0] motion;
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      last_pos <= 31'h00000000;
      motion <= MOT_STILL;
    end else if (PRIMARY_POSITION_VALID) begin
      last_pos <= PRIMARY_POSITION;
      if (PRIMARY_POSITION > last_pos) motion <= MOT_FWD; // RL23
      else if (PRIMARY_POSITION < last_pos) motion <= MOT_BACK;
      else motion <= MOT_STILL;
    end
  end

  // Plausibility timer; the 650 ms lag sits inside the skew window
  logic mismatch, skew_hit;
  logic [TMR_W-1:0] skew_cnt;
  assign mismatch = test_pair != MOT_SAFE && test_pair != motion; // RL2 RL3
  assign skew_hit = mismatch && skew_cnt == TMR_W'(SKEW_LIMIT - 1); // RL25
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) skew_cnt <= '0;
    else if (!mismatch) skew_cnt <= '0;
    else if (!skew_hit) skew_cnt <= skew_cnt + TMR_W'(1);
  end

  // Speed limit channel discrepancy timer, idle when no source is fitted
  logic sls_diff, sls_hit;
  logic [TMR_W-1:0] sls_cnt;
  assign sls_diff = cfg.sls_enable && sls_n[0] != sls_n[1]; // RL17
  assign sls_hit = sls_diff && sls_cnt == TMR_W'(SLS_LIMIT - 1); // RL16 RL26
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) sls_cnt <= '0;
    else if (!sls_diff) sls_cnt <= '0;
    else if (!sls_hit) sls_cnt <= sls_cnt + TMR_W'(1);
  end

  // Limited speed only when both channels agree low
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) LIMITED_SPEED_ACTIVE <= 1'b0;
    else LIMITED_SPEED_ACTIVE <= cfg.sls_enable && sls_n == 2'b00; // RL15 RL17
  end

  // Sticky fault flags; a new fault beats a reset in the same cycle
  logic f_estop, f_safe, f_skew, f_sls, fault_now, rst_fall, rst_q, start_q, start_rise;
  logic fault_clr;
  assign fault_now = estop != 2'b11 || test_pair == MOT_SAFE || skew_hit || sls_hit;
  assign rst_fall = rst_q && !rst_btn; // RL19
  assign start_rise = !start_q && start_btn;
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      rst_q <= 1'b0;
      start_q <= 1'b0;
    end else begin
      rst_q <= rst_btn;
      start_q <= start_btn;
    end
  end

  spsi_state_t state, next_state;
  assign fault_clr = rst_fall && !fault_now; // RL20
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      f_estop <= 1'b0;
      f_safe <= 1'b0;
      f_skew <= 1'b0;
      f_sls <= 1'b0;
    end else begin
      f_estop <= (estop != 2'b11) || (f_estop && !fault_clr); // RL22
      f_safe <= (test_pair == MOT_SAFE) || (f_safe && !fault_clr); // RL1 RL24
      f_skew <= skew_hit || (f_skew && !fault_clr); // RL25
      f_sls <= sls_hit || (f_sls && !fault_clr); // RL26
    end
  end

  // Stop ramp timer, runs only in the ramp state
  logic [TMR_W-1:0] ramp_cnt;
  logic ramp_done;
  assign ramp_done = ramp_cnt == TMR_W'(RAMP_LIMIT - 1);
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) ramp_cnt <= '0;
    else if (state != ST_RAMP) ramp_cnt <= '0;
    else if (!ramp_done) ramp_cnt <= ramp_cnt + TMR_W'(1);
  end

  // Supervisor: power-up is a latched stop awaiting reset
  always_comb begin
    next_state = state;
    case (state)
      ST_RUN: begin
        if (fault_now) next_state = cfg.ramp_used ? ST_RAMP : ST_STOPPED; // RL11
      end
      ST_RAMP: begin
        if (ramp_done) next_state = ST_STOPPED;
      end
      ST_STOPPED: begin
        if (fault_clr) next_state = ST_READY; // RL18 RL19 RL20
      end
      ST_READY: begin
        if (fault_now) next_state = ST_STOPPED;
        else if (start_rise) next_state = ST_RUN; // RL21
      end
      default: next_state = ST_STOPPED;
    endcase
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) state <= ST_STOPPED;
    else state <= next_state;
  end

  // Outputs follow state; each pair is driven from one term
  always_comb begin
    STOP_RAMP_REQUEST_OUT = state == ST_RUN; // RL10
    TORQUE_CUTOFF_OUT = {2{state == ST_RUN || state == ST_RAMP}}; // RL12 RL13
    BRAKE_HOLD_OUT = {2{cfg.brake_used && state == ST_RUN}}; // RL13 RL14
  end

  assign status = '{state: state, sls_active: LIMITED_SPEED_ACTIVE, motion: motion,
                    f_sls: f_sls, f_skew: f_skew, f_safe_req: f_safe, f_estop: f_estop,
                    latched: state == ST_STOPPED || state == ST_RAMP};

  // Position port toward the process controller
  spsi_link #(.FRAME_GAP(FRAME_GAP)) u_link (
    .clk(CLK),
    .rst(SYS_RST),
    .master(cfg.link_master),
    .long_frame(cfg.long_frame),
    .half_div(half_div),
    .pos(last_pos),
    .err(PRIMARY_POSITION_ERR),
    .link_clk(link_clk),
    .clk_out(LINK_CLK_OUT),
    .clk_oe(LINK_CLK_OE),
    .data_out(LINK_DATA_OUT)
  );

  chk_safe_request_stop: assert property (@(posedge CLK) disable iff (SYS_RST)
    test_pair == MOT_SAFE && state == ST_RUN |=> state != ST_RUN) else $error("safe request ignored"); // RL24
  chk_torque_pair_equal: assert property (@(posedge CLK) disable iff (SYS_RST)
    TORQUE_CUTOFF_OUT[0] == TORQUE_CUTOFF_OUT[1]) else $error("torque channels differ"); // RL13
  chk_brake_run_only: assert property (@(posedge CLK) disable iff (SYS_RST)
    BRAKE_HOLD_OUT != 2'b00 |-> BRAKE_HOLD_OUT == 2'b11 && state == ST_RUN) else $error("brake released"); // RL14
  chk_stop_latch_hold: assert property (@(posedge CLK) disable iff (SYS_RST)
    state == ST_STOPPED && !rst_fall |=> state == ST_STOPPED) else $error("stop left without reset"); // RL18
  chk_reset_needs_ok: assert property (@(posedge CLK) disable iff (SYS_RST)
    state == ST_STOPPED && fault_now |=> state == ST_STOPPED) else $error("reset with fault"); // RL20
  chk_start_after_reset: assert property (@(posedge CLK) disable iff (SYS_RST)
    $rose(state == ST_RUN) |-> $past(state) == ST_READY && $past(start_rise)) else $error("bad start"); // RL21
  chk_estop_stop: assert property (@(posedge CLK) disable iff (SYS_RST)
    estop != 2'b11 |=> f_estop ##1 state != ST_RUN) else $error("estop not latched"); // RL22
  chk_skew_fault: assert property (@(posedge CLK) disable iff (SYS_RST)
    skew_hit |=> f_skew && (state == ST_STOPPED || state == ST_RAMP)) else $error("skew fault missing"); // RL25
  chk_sls_fault: assert property (@(posedge CLK) disable iff (SYS_RST)
    sls_hit |=> f_sls) else $error("speed limit discrepancy missed"); // RL26
  chk_no_ramp_cut: assert property (@(posedge CLK) disable iff (SYS_RST)
    state == ST_RUN && fault_now && !cfg.ramp_used |=> TORQUE_CUTOFF_OUT == 2'b00) else $error("torque kept"); // RL11
  chk_stop_request_low: assert property (@(posedge CLK) disable iff (SYS_RST)
    state != ST_RUN |-> !STOP_RAMP_REQUEST_OUT) else $error("stop request high"); // RL10
  chk_sls_disabled: assert property (@(posedge CLK) disable iff (SYS_RST)
    !cfg.sls_enable |=> !LIMITED_SPEED_ACTIVE) else $error("disabled speed limit active"); // RL17
endmodule // spsi_top
`default_nettype wire

/* File: testbench/spsi_ctrl_model.sv */
// Process controller model acting as serial clock master on the position link
`timescale 1ns/1ps
`default_nettype none
module spsi_ctrl_model (
  output logic link_clk,
  input wire logic link_data
);
  // The clock stands high outside frames
  initial link_clk = 1'b1;

  // One frame: the fall latches the word, each rise shifts a bit out
  task automatic frame(input int nbits, output logic [31:0] word);
    word = '0;
    #7;
    link_clk = 1'b0;
    #80;
    for (int i = 0; i < nbits; i++) begin
      link_clk = 1'b1;
      #80;
      word = {word[30:0], link_data};
      if (i < nbits - 1) begin
        link_clk = 1'b0;
        #80;
      end
    end
    // Idle past the data timeout so the next frame starts clean
    #25000;
  endtask
endmodule // spsi_ctrl_model
`default_nettype wire

/* File: testbench/tb_top.sv */
// Self-checking testbench of the safe position signal interface
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import spsi_pkg::*;
  logic clk = 0, sys_rst = 1, hsel = 0, hwrite = 0, sig1 = 1, sig2 = 1;
  logic rst_btn = 0, start_btn = 0, pvalid = 0, perr = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata;
  logic [1:0] htrans = 0, sls_n = 2'h3, estop = 2'h3, torque, brake;
  logic [30:0] pos = 0;
  logic hready, hresp, lclk_out, lclk_oe, ldata, ramp_n, sls_act, ctl_clk;
  wire logic link;
  int n_fail = 0, tests_run = 0;

  // Link wire level: the device drives it only while its enable is high
  assign link = lclk_oe ? lclk_out : ctl_clk;
  always #10 clk = ~clk;

  spsi_top #(.SKEW_LIMIT(200), .SLS_LIMIT(300), .RAMP_LIMIT(50), .FRAME_GAP(3000)) dut_u (
    .CLK(clk), .SYS_RST(sys_rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
    .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp),
    .TEST_SIG1(sig1), .TEST_SIG2(sig2), .LIMITED_SPEED_REQUEST_N(sls_n), .EMERGENCY_STOP_BUTTON(estop),
    .RESET_BUTTON(rst_btn), .START_BUTTON(start_btn), .PRIMARY_POSITION(pos), .PRIMARY_POSITION_ERR(perr),
    .PRIMARY_POSITION_VALID(pvalid), .LINK_CLK_IN(link), .LINK_CLK_OUT(lclk_out), .LINK_CLK_OE(lclk_oe),
    .LINK_DATA_OUT(ldata), .STOP_RAMP_REQUEST_OUT(ramp_n), .TORQUE_CUTOFF_OUT(torque),
    .BRAKE_HOLD_OUT(brake), .LIMITED_SPEED_ACTIVE(sls_act));

  spsi_ctrl_model pm_u (.link_clk(ctl_clk), .link_data(ldata));

  task automatic complete_run;
    if (n_fail == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Outputs settle after the edge, so they are looked at mid-cycle
  task automatic outs(input logic [5:0] e);
    @(negedge clk);
    chk(32'({sls_act, ramp_n, torque, brake}), 32'(e));
    @(posedge clk);
  endtask

  // Single AHB transfer; address phase held until ready, then data phase
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    chk(x, e);
  endtask

  task automatic stat(input logic [3:0] s, input logic [4:0] m, input logic [4:0] f);
    logic [31:0] x;
    bus(1'b0, STAT_OFS, 32'h0, x);
    chk(32'({x[11:8], x[4:0] & m}), 32'({s, f}));
  endtask

  task automatic pulse(input logic [30:0] p, input logic e);
    pos <= p;
    perr <= e;
    pvalid <= 1'b1;
    @(posedge clk);
    pvalid <= 1'b0;
  endtask

  // Healthy pins, manual reset on the falling edge, then start
  task automatic arm;
    {sig1, sig2} <= MOT_STILL;
    estop <= 2'h3;
    sls_n <= 2'h3;
    cyc(4);
    rst_btn <= 1'b1;
    cyc(4);
    stat(ST_STOPPED, 5'h01, 5'h01);
    rst_btn <= 1'b0;
    cyc(5);
    outs(6'h00);
    stat(ST_READY, 5'h01, 5'h00);
    start_btn <= 1'b1;
    cyc(5);
    start_btn <= 1'b0;
    outs(6'h1f);
  endtask

  task automatic s_regs;
    rdc(CTRL_OFS, 32'h1c);
    rdc(DIV_OFS, 32'h64);
    rdc(8'h10, 32'h0);
    wr(DIV_OFS, 32'h0);
    rdc(DIV_OFS, 32'h64);
    chk(32'(hresp), 32'h0);
    outs(6'h00);
    start_btn <= 1'b1;
    cyc(5);
    start_btn <= 1'b0;
    outs(6'h00);
  endtask

  task automatic s_estop;
    arm;
    estop <= 2'h2;
    cyc(6);
    outs(6'h0c);
    cyc(40);
    outs(6'h0c);
    cyc(20);
    outs(6'h00);
    rst_btn <= 1'b1;
    cyc(4);
    rst_btn <= 1'b0;
    cyc(5);
    stat(ST_STOPPED, 5'h03, 5'h03);
    estop <= 2'h3;
    cyc(20);
    outs(6'h00);
  endtask

  task automatic s_safe;
    wr(CTRL_OFS, 32'h18);
    arm;
    {sig1, sig2} <= MOT_SAFE;
    cyc(5);
    outs(6'h00);
    stat(ST_STOPPED, 5'h04, 5'h04);
  endtask

  // Each direction code against matching motion, then a late and a wrong code
  task automatic s_dir;
    logic [1:0] c [3] = '{MOT_FWD, MOT_BACK, MOT_STILL};
    logic [30:0] p = 31'h100;
    arm;
    for (int k = 0; k < 3; k++) begin
      repeat (15) begin
        p = (k == 0) ? p + 31'h5 : (k == 1) ? p - 31'h5 : p;
        pulse(p, 1'b0);
        {sig1, sig2} <= c[k];
        cyc(20);
      end
      outs(6'h1f);
    end
    {sig1, sig2} <= MOT_FWD;
    cyc(150);
    outs(6'h1f);
    {sig1, sig2} <= MOT_STILL;
    cyc(20);
    {sig1, sig2} <= MOT_FWD;
    cyc(230);
    outs(6'h00);
    stat(ST_STOPPED, 5'h08, 5'h08);
  endtask

  task automatic s_sls;
    arm;
    sls_n <= 2'h0;
    cyc(5);
    outs(6'h3f);
    sls_n <= 2'h1;
    cyc(250);
    outs(6'h1f);
    cyc(80);
    outs(6'h00);
    stat(ST_STOPPED, 5'h10, 5'h10);
    wr(CTRL_OFS, 32'h10);
    arm;
    sls_n <= 2'h0;
    cyc(400);
    outs(6'h1f);
  endtask

  task automatic s_link;
    logic [31:0] w;
    pulse(31'h5a5a5a5, 1'b1);
    pm_u.frame(25, w);
    chk(w, {7'h0, 24'ha5a5a5, 1'b1});
    @(posedge clk);
    wr(CTRL_OFS, 32'h12);
    pm_u.frame(32, w);
    chk(w, {31'h5a5a5a5, 1'b1});
    @(posedge clk);
    wr(DIV_OFS, 32'h4);
    wr(CTRL_OFS, 32'h13);
    @(negedge lclk_out);
    chk(32'(lclk_oe), 32'h1);
    w = '0;
    // Sample two cycles after each rise, well before the next one
    for (int i = 0; i < 32; i++) begin
      @(posedge lclk_out);
      cyc(2);
      w = {w[30:0], ldata};
    end
    chk(w, {31'h5a5a5a5, 1'b1});
  endtask

  // Main sequence
  initial begin
    cyc(10);
    sys_rst <= 1'b0;
    cyc(6);
    s_regs;
    s_estop;
    s_safe;
    s_dir;
    s_sls;
    s_link;
    complete_run;
  end

  // Watchdog: the full run needs about a twelfth of this span
  initial begin
    #2000000;
    n_fail++;
    complete_run;
  end
endmodule // tb_top
`default_nettype wire
